// ===== soc_led_bar_controller.sv
// Charge level LED bar controller: register file, auto-count, display modes and multiplexed drive.
`timescale 1ns/100ps

// How it works
// - Twelve LEDs are scanned one at a time over four pins.
// - After reset LEDs are probed in order up to the first dark one to count populated ones.
// - Lit bar count follows the reported charge level.
// - PWM duty is scaled by supply headroom to keep brightness steady.
// - Display starts from a button press or a register write.
// - Button modes light for a timer period or while held.
// - Forced mode stays lit until the host changes the mode.
// - Gray mode shows the remainder bar at half intensity.
// - Empty LED option reserves LED0, lit alone when no bar or gray bar shows.
// - Gray bar and last remaining bar can blink with configurable timing.
// - Rising auto-count enable restarts the LED count.
// - Any LED activity raises the wake request.
// - Bar count field is overwritten with the detected count.
// - Gray clear rounds bars; gray set truncates and grays remainder.
// - Charge light bit keeps LEDs on while charge current exceeds threshold.
// - Two-bit mode picks off, timed, button or forced.
// - Animation applies only in timed and forced modes.
// - Animation selects solid, fill, breathing or both.
// - Larger step size makes animation faster.
// - Timer field picks the termination time from eight values.
// - Timer field picks the blink interval from five values; the lowest four settings share 400 ms.
// - Full blink makes all LEDs blink when full.
module soc_led_bar_controller (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire led_bar_pkg::reg_req_type     reg_req_i,
	output logic [15:0]                       reg_rdata_o,
	input  wire logic [15:0]                  reported_charge_level_i,
	input  wire led_bar_pkg::supply_type      supply_i,
	input  wire logic                         button_i,
	input  wire logic                         led_sense_i,
	output logic [3:0]                        led_pin_o,
	output logic [3:0]                        led_pin_oe_o,
	output logic                              active_request_o
);

	typedef enum logic [1:0] {PH_START, PH_PROBE, PH_RUN} phase_type;

	typedef struct packed {
		led_bar_pkg::cfg_primary_type   cfg1;
		led_bar_pkg::cfg_secondary_type cfg2;
		logic [15:0] rdata;
		logic [6:0]  us_cnt;
		logic        us_tick;
		logic [9:0]  ms_cnt;
		logic        ms_tick;
		phase_type   phase;
		logic [3:0]  probe_idx;
		logic [5:0]  probe_wait;
		logic [3:0]  found;
		logic        auto_prev;
		logic        timed_on;
		logic [13:0] hold_ms;
		logic        blink_ph;
		logic [12:0] blink_ms;
		logic [4:0]  ani_ms;
		logic [6:0]  fill_pct;
		logic [4:0]  breath;
		logic        breath_down;
		logic [3:0]  slot;
		logic [4:0]  step;
		logic [3:0]  pin_out;
		logic [3:0]  pin_oe;
		logic        active;
	} core_state_type;

	core_state_type s_r;
	core_state_type s_nxt;

	logic        btn_level;
	logic        btn_press;
	logic        sense_level;
	logic        duty_on;
	logic        cfg1_wr;
	logic        cfg2_wr;
	logic        charging;
	logic        show;
	logic        animate;
	logic        near_empty;
	logic        probe_done;
	logic [3:0]  probe_count;
	logic [6:0]  soc_pct;
	logic [6:0]  disp_pct;
	logic [3:0]  n_bars;
	logic [3:0]  bar_base;
	logic [11:0] bar_lit;
	logic [11:0] bar_gray;
	logic [11:0] gray_mask;
	logic [11:0] on_mask;
	logic [11:0] prod;
	logic [9:0]  breath_prod;
	logic [4:0]  eff_level;
	logic [4:0]  slot_level;
	logic [3:0]  drive_idx;
	logic [1:0]  anode;
	logic [1:0]  cathode;
	logic [5:0]  inc;
	logic [5:0]  breath_sum;
	logic [7:0]  fill_sum;

	////////////////////////////////////////////////////////////////////////////////

	pin_filter #(
		.HOLD (led_bar_pkg::DEBOUNCE_MS)
	) u_button (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.tick_i  (s_r.ms_tick),
		.pin_i   (button_i),
		.level_o (btn_level),
		.rise_o  (btn_press)
	);

	// The sense comparator needs no debounce, only the pin synchroniser.
	pin_filter #(
		.HOLD (1)
	) u_sense (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.tick_i  (1'h1),
		.pin_i   (led_sense_i),
		.level_o (sense_level),
		.rise_o  ()
	);

	led_duty_comp u_duty (
		.step_i  (s_r.step),
		.level_i (slot_level),
		.cell_i  (supply_i.cell_voltage),
		.empty_i (supply_i.empty_voltage),
		.vled_i  (s_r.cfg2.led_voltage),
		.on_o    (duty_on)
	);

	////////////////////////////////////////////////////////////////////////////////

	// Display decode from registered state and the unregistered charge level and supply inputs: which LEDs light and how bright.
	always_comb begin
		soc_pct = (reported_charge_level_i[15:8] > {1'h0, led_bar_pkg::PCT_FULL}) ?
			led_bar_pkg::PCT_FULL : reported_charge_level_i[14:8];
		charging = s_r.cfg1.light_while_charging &&
			(supply_i.charge_current > supply_i.charge_termination_threshold);
		show = (s_r.phase == PH_RUN) && (charging ||
			(s_r.cfg1.display_mode_select == led_bar_pkg::MODE_BUTTON && btn_level) ||
			(s_r.cfg1.display_mode_select == led_bar_pkg::MODE_TIMED && s_r.timed_on) ||
			(s_r.cfg1.display_mode_select == led_bar_pkg::MODE_FORCED));
		animate = show && s_r.cfg1.animation_select != led_bar_pkg::ANI_SOLID &&
			(s_r.cfg1.display_mode_select == led_bar_pkg::MODE_TIMED ||
			s_r.cfg1.display_mode_select == led_bar_pkg::MODE_FORCED);
		disp_pct = (animate && s_r.cfg1.animation_select[0] && s_r.fill_pct < soc_pct) ?
			s_r.fill_pct : soc_pct;
		bar_base = {3'h0, s_r.cfg2.empty_led_enable && s_r.cfg1.bar_count != 4'h0};
		n_bars   = (s_r.cfg1.bar_count > led_bar_pkg::LED_LAST + 4'h1) ?
			led_bar_pkg::LED_LAST + 4'h1 - bar_base : s_r.cfg1.bar_count - bar_base;
		prod     = 12'(disp_pct) * 12'(n_bars);
		for (int b = 0; b < led_bar_pkg::NUM_LEDS; b++) begin
			bar_lit[b]  = (4'(b) < n_bars) && ((prod + (s_r.cfg1.remainder_gray_enable ?
				12'h000 : led_bar_pkg::PCT_HALF)) >= 12'(b + 1) * led_bar_pkg::PCT_STEP);
			bar_gray[b] = s_r.cfg1.remainder_gray_enable && (4'(b) < n_bars) &&
				!bar_lit[b] && (prod > 12'(b) * led_bar_pkg::PCT_STEP);
		end
		gray_mask  = bar_gray << bar_base;
		on_mask    = (bar_lit | bar_gray) << bar_base;
		near_empty = !bar_lit[1] && !bar_gray[1];
		if (bar_base != 4'h0 && bar_lit == 12'h000 && bar_gray == 12'h000) begin
			on_mask[0] = 1'h1;
		end
		if (s_r.cfg2.gray_blink_enable && !s_r.blink_ph) begin
			on_mask = on_mask & ~gray_mask;
		end
		// Near empty only the lowest LED is lit, so blanking all blinks exactly that one.
		if (s_r.cfg2.empty_blink_enable && near_empty && !s_r.blink_ph) begin
			on_mask = 12'h000;
		end
		if (s_r.cfg2.full_blink_enable && soc_pct == led_bar_pkg::PCT_FULL && !s_r.blink_ph) begin
			on_mask = 12'h000;
		end
		breath_prod = {5'h00, s_r.cfg2.brightness} * {5'h00, s_r.breath};
		eff_level   = (animate && s_r.cfg1.animation_select[1]) ?
			breath_prod[9:5] : s_r.cfg2.brightness;
		slot_level  = gray_mask[s_r.slot] ? (eff_level >> 1) : eff_level;
		drive_idx   = (s_r.phase == PH_PROBE) ? s_r.probe_idx : s_r.slot;
		anode       = led_bar_pkg::led_anode(drive_idx);
		cathode     = led_bar_pkg::led_cathode(drive_idx);
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		s_nxt         = s_r;
		s_nxt.us_tick = 1'h0;
		s_nxt.ms_tick = 1'h0;
		probe_done    = 1'h0;
		probe_count   = s_r.found;
		inc           = {3'h0, s_r.cfg1.animation_step_size} + 6'h01;
		breath_sum    = 6'h00;
		fill_sum      = 8'h00;

		// Microsecond and millisecond enable pulses.
		if (s_r.us_cnt == led_bar_pkg::US_LAST) begin
			s_nxt.us_cnt  = 7'h00;
			s_nxt.us_tick = 1'h1;
		end else begin
			s_nxt.us_cnt = s_r.us_cnt + 7'h01;
		end
		if (s_r.us_tick) begin
			if (s_r.ms_cnt == led_bar_pkg::MS_LAST) begin
				s_nxt.ms_cnt  = 10'h000;
				s_nxt.ms_tick = 1'h1;
			end else begin
				s_nxt.ms_cnt = s_r.ms_cnt + 10'h001;
			end
		end

		cfg1_wr = reg_req_i.wr && reg_req_i.addr == led_bar_pkg::CFG1_ADDR;
		cfg2_wr = reg_req_i.wr && reg_req_i.addr == led_bar_pkg::CFG2_ADDR;
		if (cfg1_wr) begin
			s_nxt.cfg1 = reg_req_i.wdata;
		end
		if (cfg2_wr) begin
			s_nxt.cfg2 = reg_req_i.wdata;
		end
		unique case (reg_req_i.addr)
			led_bar_pkg::CFG1_ADDR: s_nxt.rdata = s_r.cfg1;
			led_bar_pkg::CFG2_ADDR: s_nxt.rdata = s_r.cfg2;
			default:                s_nxt.rdata = 16'h0000;
		endcase
		s_nxt.auto_prev = s_r.cfg2.auto_count_enable;

		unique case (s_r.phase)
			PH_START: begin
				s_nxt.phase      = PH_PROBE;
				s_nxt.probe_idx  = 4'h0;
				s_nxt.probe_wait = 6'h00;
				s_nxt.found      = 4'h0;
			end
			PH_PROBE: begin
				if (s_r.us_tick) begin
					if (s_r.probe_wait == led_bar_pkg::PROBE_LAST) begin
						s_nxt.probe_wait = 6'h00;
						// Populate-in-order wiring means the first dark LED ends the count.
						if (!sense_level) begin
							probe_done = 1'h1;
						end else if (s_r.probe_idx == led_bar_pkg::LED_LAST) begin
							probe_done  = 1'h1;
							probe_count = s_r.found + 4'h1;
						end else begin
							s_nxt.found     = s_r.found + 4'h1;
							s_nxt.probe_idx = s_r.probe_idx + 4'h1;
						end
					end else begin
						s_nxt.probe_wait = s_r.probe_wait + 6'h01;
					end
				end
			end
			PH_RUN: begin
				if (s_r.cfg2.auto_count_enable && !s_r.auto_prev) begin
					s_nxt.phase = PH_START;
				end
			end
		endcase
		// detected count wins over a host write
		if (probe_done) begin
			s_nxt.phase          = PH_RUN;
			s_nxt.cfg1.bar_count = probe_count;
		end

		if ((btn_press && s_r.cfg1.display_mode_select == led_bar_pkg::MODE_TIMED) ||
			(cfg1_wr && reg_req_i.wdata[7:6] == led_bar_pkg::MODE_TIMED)) begin
			s_nxt.timed_on = 1'h1;
			s_nxt.hold_ms  = 14'h0000;
		end else if (s_r.cfg1.display_mode_select != led_bar_pkg::MODE_TIMED) begin
			s_nxt.timed_on = 1'h0;
		end else if (s_r.timed_on && s_r.ms_tick) begin
			if (s_r.hold_ms + 14'h0001 >=
				led_bar_pkg::TERM_MS[s_r.cfg1.display_time_select]) begin
				s_nxt.timed_on = 1'h0;
			end else begin
				s_nxt.hold_ms = s_r.hold_ms + 14'h0001;
			end
		end

		if (s_r.ms_tick) begin
			if (s_r.blink_ms + 13'h0001 >=
				led_bar_pkg::BLINK_MS[s_r.cfg1.display_time_select]) begin
				s_nxt.blink_ms = 13'h0000;
				s_nxt.blink_ph = !s_r.blink_ph;
			end else begin
				s_nxt.blink_ms = s_r.blink_ms + 13'h0001;
			end
		end

		if (!animate) begin
			s_nxt.ani_ms      = 5'h00;
			s_nxt.fill_pct    = 7'h00;
			s_nxt.breath      = 5'h00;
			s_nxt.breath_down = 1'h0;
		end else if (s_r.ms_tick) begin
			if (s_r.ani_ms == led_bar_pkg::ANI_LAST) begin
				s_nxt.ani_ms = 5'h00;
				fill_sum     = {1'h0, s_r.fill_pct} + {2'h0, inc};
				s_nxt.fill_pct = (fill_sum >= {1'h0, led_bar_pkg::PCT_FULL}) ?
					led_bar_pkg::PCT_FULL : fill_sum[6:0];
				if (s_r.breath_down) begin
					if ({1'h0, s_r.breath} <= inc) begin
						s_nxt.breath      = 5'h00;
						s_nxt.breath_down = 1'h0;
					end else begin
						s_nxt.breath = s_r.breath - inc[4:0];
					end
				end else begin
					breath_sum = {1'h0, s_r.breath} + inc;
					if (breath_sum >= {1'h0, led_bar_pkg::LEVEL_MAX}) begin
						s_nxt.breath      = led_bar_pkg::LEVEL_MAX;
						s_nxt.breath_down = 1'h1;
					end else begin
						s_nxt.breath = breath_sum[4:0];
					end
				end
			end else begin
				s_nxt.ani_ms = s_r.ani_ms + 5'h01;
			end
		end

		// slot scan, 32 PWM steps per LED
		if (s_r.us_tick) begin
			s_nxt.step = s_r.step + 5'h01;
			if (s_r.step == led_bar_pkg::STEP_LAST) begin
				s_nxt.slot = (s_r.slot == led_bar_pkg::LED_LAST) ? 4'h0 : s_r.slot + 4'h1;
			end
		end
		// drive one LED pair, others floating
		s_nxt.pin_oe  = 4'h0;
		s_nxt.pin_out = 4'h0;
		if (s_r.phase == PH_PROBE || (show && on_mask[s_r.slot] && duty_on)) begin
			s_nxt.pin_oe[anode]   = 1'h1;
			s_nxt.pin_oe[cathode] = 1'h1;
			s_nxt.pin_out[anode]  = 1'h1;
		end
		s_nxt.active = show || s_r.phase != PH_RUN;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r      <= '0;
			s_r.cfg1 <= led_bar_pkg::CFG1_RESET;
			s_r.cfg2 <= led_bar_pkg::CFG2_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata_o      = s_r.rdata;
	assign led_pin_o        = s_r.pin_out;
	assign led_pin_oe_o     = s_r.pin_oe;
	assign active_request_o = s_r.active;

endmodule

// ===== led_bar_pkg.sv
// Shared constants, register layouts and carrier types of the charge LED bar controller.
package led_bar_pkg;

	// Clock and derived tick rates.
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_US_NS    = 1000;
	localparam int US_CYCLES     = TICK_US_NS / CLK_PERIOD_NS;
	localparam int MS_US         = 1000;
	localparam logic [6:0] US_LAST = 7'(US_CYCLES - 1);
	localparam logic [9:0] MS_LAST = 10'(MS_US - 1);

	// Probe dwell per LED during auto-count, animation update period, button debounce.
	localparam int PROBE_US       = 50;
	localparam int ANI_UPDATE_MS  = 25;
	localparam int DEBOUNCE_MS    = 20;
	localparam logic [5:0] PROBE_LAST = 6'(PROBE_US - 1);
	localparam logic [4:0] ANI_LAST   = 5'(ANI_UPDATE_MS - 1);

	// LED network geometry.
	localparam int NUM_LEDS = 12;
	localparam int NUM_PINS = 4;
	localparam logic [3:0] LED_LAST  = 4'(NUM_LEDS - 1);
	localparam logic [3:0] PIN_PEERS = 4'(NUM_PINS - 1);
	localparam logic [4:0] STEP_LAST = 5'h1F;
	localparam logic [4:0] LEVEL_MAX = 5'h1F;

	// Register map.
	localparam logic [7:0]  CFG1_ADDR  = 8'h40;
	localparam logic [7:0]  CFG2_ADDR  = 8'h4B;
	localparam logic [15:0] CFG1_RESET = 16'h6070;
	localparam logic [15:0] CFG2_RESET = 16'h011F;

	// Display mode and animation encodings.
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_TIMED  = 2'h1;
	localparam logic [1:0] MODE_BUTTON = 2'h2;
	localparam logic [1:0] MODE_FORCED = 2'h3;
	localparam logic [1:0] ANI_SOLID   = 2'h0;

	// Charge level scale in percent.
	localparam logic [6:0]  PCT_FULL  = 7'h64;
	localparam logic [11:0] PCT_STEP  = 12'h064;
	localparam logic [11:0] PCT_HALF  = 12'h032;

	// Termination times and blink intervals in milliseconds, indexed by the timer field.
	localparam logic [13:0] TERM_MS [0:7] = '{14'h0064, 14'h012C, 14'h0258, 14'h0514,
		14'h0A8C, 14'h157C, 14'h2198, 14'h2710};
	localparam logic [12:0] BLINK_MS [0:7] = '{13'h0190, 13'h0190, 13'h0190, 13'h0190,
		13'h02BC, 13'h0578, 13'h0AF0, 13'h15E0};

	typedef struct packed {
		logic [2:0] display_time_select;
		logic [2:0] animation_step_size;
		logic [1:0] animation_select;
		logic [1:0] display_mode_select;
		logic       light_while_charging;
		logic       remainder_gray_enable;
		logic [3:0] bar_count;
	} cfg_primary_type;

	typedef struct packed {
		logic       empty_led_enable;
		logic [5:0] led_voltage;
		logic       auto_count_enable;
		logic       gray_blink_enable;
		logic       empty_blink_enable;
		logic       full_blink_enable;
		logic [4:0] brightness;
	} cfg_secondary_type;

	typedef struct packed {
		logic [7:0]  addr;
		logic        wr;
		logic [15:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic signed [15:0] charge_current;
		logic signed [15:0] charge_termination_threshold;
		logic [7:0]         cell_voltage;
		logic [7:0]         empty_voltage;
	} supply_type;

	// LED k sits between anode pin k/3 and the k%3-th of the remaining pins.
	function automatic logic [1:0] led_anode(input logic [3:0] idx);
		return 2'(idx / PIN_PEERS);
	endfunction

	function automatic logic [1:0] led_cathode(input logic [3:0] idx);
		logic [1:0] a;
		logic [1:0] r;
		a = 2'(idx / PIN_PEERS);
		r = 2'(idx % PIN_PEERS);
		return (r < a) ? r : r + 2'h1;
	endfunction

endpackage

// ===== pin_filter.sv
// Three-stage pin synchroniser with agreement check and tick-based debounce.
`timescale 1ns/100ps

module pin_filter #(
	parameter int HOLD = 20
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic tick_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o
);

	localparam int CW = $clog2(HOLD + 1);

	typedef struct packed {
		logic [2:0]    sync;
		logic          level;
		logic          rise;
		logic [CW-1:0] cnt;
	} filt_state_type;

	filt_state_type s_r;
	filt_state_type s_nxt;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		s_nxt = s_r;
		s_nxt.sync = {s_r.sync[1:0], pin_i};
		s_nxt.rise = 1'h0;
		// A new level must stay agreed for HOLD ticks; any disagreement restarts the wait.
		if (s_r.sync[1] != s_r.sync[2] || s_r.sync[2] == s_r.level) begin
			s_nxt.cnt = '0;
		end else if (tick_i) begin
			if (int'(s_r.cnt) + 1 >= HOLD) begin
				s_nxt.cnt   = '0;
				s_nxt.level = s_r.sync[2];
				s_nxt.rise  = s_r.sync[2];
			end else begin
				s_nxt.cnt = s_r.cnt + CW'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level_o = s_r.level;
	assign rise_o  = s_r.rise;

endmodule

// ===== led_duty_comp.sv
// Supply-compensated PWM compare for one multiplexed LED slot.
`timescale 1ns/100ps

module led_duty_comp (
	input  wire logic [4:0] step_i,
	input  wire logic [4:0] level_i,
	input  wire logic [7:0] cell_i,
	input  wire logic [7:0] empty_i,
	input  wire logic [5:0] vled_i,
	output logic            on_o
);

	logic [8:0]  cell_head;
	logic [8:0]  empty_head;
	logic [13:0] lhs;
	logic [13:0] rhs;

	// Duty = level * (empty - vled) / (cell - vled), done as a cross-multiplied compare.
	always_comb begin
		cell_head  = {1'h0, cell_i} - {3'h0, vled_i};
		empty_head = {1'h0, empty_i} - {3'h0, vled_i};
		lhs        = {5'h00, cell_head} * {9'h000, step_i};
		rhs        = {5'h00, empty_head} * {9'h000, level_i};
		// Without headroom above the LED voltage the compensation has no meaning.
		if (cell_i <= {2'h0, vled_i} || empty_i <= {2'h0, vled_i}) begin
			on_o = step_i < level_i;
		end else begin
			on_o = lhs < rhs;
		end
	end

endmodule

// ===== led_bar_checker.sv
// Port assertions of the LED bar controller.
`timescale 1ns/100ps

module led_bar_checker (
	input wire logic                     clk_i,
	input wire logic                     rst_i,
	input wire led_bar_pkg::reg_req_type reg_req_i,
	input wire logic [15:0]              reg_rdata_o,
	input wire logic [3:0]               led_pin_o,
	input wire logic [3:0]               led_pin_oe_o,
	input wire logic                     active_request_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////
	// pair only.
	pin_pair_a: assert property (led_pin_oe_o == 4'h0 || $countones(led_pin_oe_o) == 2)
		else $error("pin enables not a pair");
	one_anode_a: assert property (led_pin_oe_o != 4'h0 |-> $countones(led_pin_o & led_pin_oe_o) == 1)
		else $error("driven pair lacks a single anode");
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> led_pin_oe_o == 4'h0 &&
		!active_request_o && reg_rdata_o == 16'h0000) else $error("outputs busy after reset");
	count_start_a: assert property ($fell(rst_i) |-> ##[0:3] active_request_o)
		else $error("no auto-count after reset");
	unmapped_zero_a: assert property (reg_req_i.addr != 8'h40 && reg_req_i.addr != 8'h4B |=>
		reg_rdata_o == 16'h0000) else $error("unmapped read not zero");
	write_back_a: assert property (reg_req_i.wr && reg_req_i.addr == 8'h40 ##1
		reg_req_i.addr == 8'h40 && !reg_req_i.wr |=> reg_rdata_o == $past(reg_req_i.wdata, 2))
		else $error("written config not read back");
	forced_wake_a: assert property (reg_req_i.wr && reg_req_i.addr == 8'h40 &&
		reg_req_i.wdata[7:6] == 2'h3 |-> ##[1:4] active_request_o) else $error("forced mode idle");
	drive_wake_a: assert property (led_pin_oe_o != 4'h0 |-> active_request_o ||
		$past(active_request_o)) else $error("pins driven while asleep");
	forced_c: cover property (reg_req_i.wr && reg_req_i.wdata[7:6] == 2'h3);
	wake_c: cover property ($rose(active_request_o));
	drive_c: cover property (led_pin_oe_o != 4'h0);
endmodule

// ===== led_net_model.sv
// Behavioural multiplexed LED network with current sense and push-button.
`timescale 1ns/100ps

module led_net_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] pin_i,
	input  wire logic [3:0] oe_i,
	input  wire logic [3:0] fitted_i,
	input  wire logic       clear_i,
	input  wire logic       press_i,
	output logic            sense_o,
	output logic            button_o,
	output logic [11:0]     lit_o
);
	logic [3:0] hi;
	logic [3:0] lo;
	logic [3:0] idx;
	logic       pair;
	function automatic logic [1:0] pos(input logic [3:0] v);
		return v[3] ? 2'h3 : v[2] ? 2'h2 : v[1] ? 2'h1 : 2'h0;
	endfunction
	assign hi = oe_i & pin_i;
	assign lo = oe_i & ~pin_i;
	assign pair = $countones(hi) == 1 && $countones(lo) == 1;
	// decode the pair. Cathodes above the anode skip the anode pin.
	assign idx = 4'(pos(hi)) * 4'h3 + 4'(pos(lo)) - ((pos(lo) > pos(hi)) ? 4'h1 : 4'h0);
	// only fitted LEDs conduct, populated from LED0 upward.
	assign sense_o = pair && idx < fitted_i;
	assign button_o = press_i;
	always_ff @(posedge clk_i) begin
		if (clear_i) begin
			lit_o <= 12'h000;
		end else if (pair) begin
			lit_o[idx] <= 1'b1;
		end
	end
endmodule

// ===== testbench.sv
// Self-checking bench: registers, auto-count and empty-LED bar display.
`timescale 1ns/100ps

`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end

module testbench;
	logic                     clk_i;
	logic                     rst_i;
	led_bar_pkg::reg_req_type req;
	led_bar_pkg::supply_type  supply;
	logic [15:0]              rdata;
	logic [15:0]              level;
	logic                     button;
	logic                     sense;
	logic [3:0]               pin;
	logic [3:0]               oe;
	logic                     active;
	logic [3:0]               fitted;
	logic                     clear;
	logic                     press;
	logic [11:0]              lit;
	logic [15:0]              seed;
	logic [15:0]              rd;
	logic [6:0]               pct;
	int                       n_mismatch;
	int                       n_compared;
	int                       cycles;

	soc_led_bar_controller uut (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req),
		.reg_rdata_o(rdata), .reported_charge_level_i(level), .supply_i(supply),
		.button_i(button), .led_sense_i(sense), .led_pin_o(pin), .led_pin_oe_o(oe),
		.active_request_o(active));
	led_net_model net (.clk_i(clk_i), .pin_i(pin), .oe_i(oe), .fitted_i(fitted),
		.clear_i(clear), .press_i(press), .sense_o(sense), .button_o(button), .lit_o(lit));
	////////////////////////////////////////
	function automatic logic [15:0] xs(input logic [15:0] v);
		logic [15:0] x;
		x = v ^ (v << 7);
		x = x ^ (x >> 9);
		return x ^ (x << 8);
	endfunction
	// Empty LED on LED0, bars on LED1 upward, rounded.
	function automatic logic [11:0] exp_mask(input logic [6:0] p, input logic [3:0] n);
		logic [11:0] m;
		int          nb;
		m = 12'h000;
		nb = n - 1;
		for (int b = 1; b <= nb; b++) begin
			if (p * nb + 50 >= 100 * b) begin
				m[b] = 1'b1;
			end
		end
		m[0] = (m == 12'h000);
		return m;
	endfunction
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		req.addr = a;
		req.wr = 1'b1;
		req.wdata = d;
		@(posedge clk_i);
		#1;
		req.wr = 1'b0;
		// An idle edge keeps a following write from raising the strobe in this same step.
		@(posedge clk_i);
		#1;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [15:0] d);
		req.addr = a;
		@(posedge clk_i);
		#1;
		d = rdata;
	endtask
	task automatic wait_active(input logic v, input int lim);
		for (int i = 0; i < lim && active !== v; i++) begin
			@(posedge clk_i);
			#1;
		end
		`CHK(active, v)
	endtask
	task automatic report_and_stop();
		$display("compared=%0d mismatched=%0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Counts of 3 and 6 probes at 50 us, one 384 us frame and traffic: about 86k cycles.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 99000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		n_mismatch = 0;
		n_compared = 0;
		cycles = 0;
		rst_i = 1'b1;
		req = '0;
		seed = xs(16'h5AF3);
		pct = 7'(seed % 16'h0065);
		level = {1'b0, pct, 8'h00};
		fitted = 4'h2;
		clear = 1'b0;
		press = 1'b0;
		supply = '{16'sh0040, 16'sh0040, 8'h00, 8'h00};
		repeat (20) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		@(posedge clk_i);
		#1;
		reg_rd(8'h40, rd);
		`CHK(rd, 16'h6070)
		reg_rd(8'h4B, rd);
		`CHK(rd, 16'h011F)
		seed = xs(seed);
		reg_wr(8'h41, seed);
		reg_rd(8'h41, rd);
		`CHK(rd, 16'h0000)
		wait_active(1'b0, 30000);
		reg_rd(8'h40, rd);
		`CHK(rd, 16'h6072)
		// A press far shorter than the debounce time must not start the timed display.
		press = 1'b1;
		repeat (500) @(posedge clk_i);
		#1;
		press = 1'b0;
		repeat (20) @(posedge clk_i);
		#1;
		`CHK(active, 1'b0)
		fitted = 4'h5;
		reg_wr(8'h4B, 16'h001F);
		reg_wr(8'h4B, 16'h011F);
		wait_active(1'b1, 100);
		wait_active(1'b0, 40000);
		reg_rd(8'h40, rd);
		`CHK(rd, 16'h6075)
		reg_wr(8'h4B, 16'h811F);
		reg_wr(8'h40, 16'h00C5);
		reg_rd(8'h40, rd);
		`CHK(rd, 16'h00C5)
		wait_active(1'b1, 100);
		clear = 1'b1;
		@(posedge clk_i);
		#1;
		clear = 1'b0;
		repeat (40000) @(posedge clk_i);
		#1;
		`CHK(lit, exp_mask(pct, 4'h5))
		reg_wr(8'h40, 16'h0005);
		wait_active(1'b0, 2000);
		report_and_stop();
	end
endmodule

bind soc_led_bar_controller led_bar_checker chk (.clk_i(clk_i), .rst_i(rst_i),
	.reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o), .led_pin_o(led_pin_o),
	.led_pin_oe_o(led_pin_oe_o), .active_request_o(active_request_o));
